// ==== logic/aawc_params.svh ====
// Purpose: Constants of the area access and wait configuration block.
// Assumes: Included by its bare name from the top module only.
// Notes:   Byte offsets sit on the classic Wishbone slave, one word each.
`ifndef AAWC_PARAMS_SVH
`define AAWC_PARAMS_SVH

// Register byte offsets.
`define AAWC_OFS_ACCESS_STATE_SELECT  8'h00
`define AAWC_OFS_WAIT_COUNT_UPPER     8'h04
`define AAWC_OFS_WAIT_COUNT_LOWER     8'h08
`define AAWC_OFS_LAST_TIMING          8'h0C

// Reset values of the three configuration registers.
`define AAWC_RST_ACCESS_STATE_SELECT  8'hFF
`define AAWC_RST_WAIT_COUNT_UPPER     8'hFF
`define AAWC_RST_WAIT_COUNT_LOWER     8'hFF

// Field positions of the last timing register.
`define AAWC_LT_STATES_LSB            0
`define AAWC_LT_WAITS_LSB             4

// State counts of each kind of access.
`define AAWC_STATES_TWO               3'h2
`define AAWC_STATES_THREE_BASE        3'h3
`define AAWC_STATES_ONCHIP            3'h2
`define AAWC_STATES_DRAM              3'h3

`endif

// ==== logic/aawc_pkg.sv ====
// Purpose: Types shared by the area access and wait configuration block.
// Assumes: Nothing comes from aawc_params.svh; the state codes are literal.
// Notes:   Nothing here is imported; users write aawc_pkg::name.
package aawc_pkg;

  // Timing query from the bus cycle generator.
  typedef struct packed {
    logic       valid;
    logic       onchip;
    logic [2:0] area;
  } aawc_query_type;

  // Timing answer back to the bus cycle generator.
  typedef struct packed {
    logic       valid;
    logic [2:0] states;
    logic [1:0] waits;
  } aawc_answer_type;

  // Bus slave handshake states.
  typedef enum logic [1:0] {
    AAWC_ST_IDLE = 2'b01,
    AAWC_ST_ACK  = 2'b10
  } aawc_bus_state_type;

endpackage : aawc_pkg

// ==== logic/aawc_top.sv ====
// Purpose: Per-area access state and program wait configuration with a
//          timing lookup for the bus cycle generator.
// Assumes: Classic Wishbone slave with 32-bit data; every input except
//          hw_standby_i is on clk_sys_i and is used as it comes.
// Notes:   Registers are 8 bits wide in the low byte of each word. The map
//          holds access_state_select at 0x00, wait_count_upper_areas at
//          0x04, wait_count_lower_areas at 0x08 and a read-only word at 0x0C
//          with the states (bits 2:0) and waits (bits 5:4) of the last
//          answer. Other offsets acknowledge, drop writes and read as zero.
//          Hardware standby is a pin and passes two flops before it reloads
//          the registers, so it acts two cycles after it is first seen.
`timescale 1ns/1ns

`include "aawc_params.svh"

module aawc_top (
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  input  wire logic                    hw_standby_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [7:0]              dram_area_select_i,
  input  wire aawc_pkg::aawc_query_type query_i,
  output aawc_pkg::aawc_answer_type    answer_o,
  output logic      [7:0]              area_three_state_o,
  output logic      [15:0]             area_wait_counts_o
);

  // Configuration registers.
  logic [7:0]                   access_state_select_q;
  logic [7:0]                   wait_count_upper_areas_q;
  logic [7:0]                   wait_count_lower_areas_q;

  // Bus slave state.
  aawc_pkg::aawc_bus_state_type bus_state_q;
  aawc_pkg::aawc_bus_state_type bus_state_d;
  logic                         ack_q;
  logic [31:0]                  rdata_q;
  logic [31:0]                  rdata_d;

  // Timing lookup.
  logic [2:0]                   area_states[8];
  logic [1:0]                   area_waits[8];
  logic [15:0]                  wait_word;
  aawc_pkg::aawc_answer_type    answer_q;
  aawc_pkg::aawc_answer_type    answer_d;
  logic [2:0]                   last_states_q;
  logic [1:0]                   last_waits_q;
  logic [7:0]                   three_state_q;
  logic [15:0]                  wait_counts_q;

  // Decoded bus strobes.
  logic                         bus_req;
  logic                         wr_en;
  logic                         wr_ass;
  logic                         wr_wcu;
  logic                         wr_wcl;
  logic                         hold_init;

  // Hardware standby synchroniser.
  logic                         standby_meta_q;
  logic                         standby_sync_q;

  // A request is taken only from idle, so ack drops for one cycle between
  // two accesses and a held request is never executed twice.
  assign bus_req = wb_cyc_i && wb_stb_i && (bus_state_q == aawc_pkg::AAWC_ST_IDLE);

  // Only the low byte lane carries register data.
  assign wr_en  = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_ass = wr_en && (wb_adr_i == `AAWC_OFS_ACCESS_STATE_SELECT);
  assign wr_wcu = wr_en && (wb_adr_i == `AAWC_OFS_WAIT_COUNT_UPPER);
  assign wr_wcl = wr_en && (wb_adr_i == `AAWC_OFS_WAIT_COUNT_LOWER);

  // Reset and hardware standby both force the initial values. A write that
  // lands while either is active is lost, which is harmless because no
  // software runs while the part is held in standby.
  assign hold_init = !nrst_i || standby_sync_q;

  // Standby comes from a pin; two flops keep metastability out of the
  // register reload, at the cost of two cycles of extra latency.
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      standby_meta_q <= 1'b0;
      standby_sync_q <= 1'b0;
    end
    else
    begin
      standby_meta_q <= hw_standby_i;
      standby_sync_q <= standby_meta_q;
    end
  end

  // Next state of the bus handshake.
  always_comb
  begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      aawc_pkg::AAWC_ST_IDLE:
      begin
        if (bus_req)
        begin
          bus_state_d = aawc_pkg::AAWC_ST_ACK;
        end
      end
      aawc_pkg::AAWC_ST_ACK:
      begin
        bus_state_d = aawc_pkg::AAWC_ST_IDLE;
      end
      default:
      begin
        bus_state_d = aawc_pkg::AAWC_ST_IDLE;
      end
    endcase
  end

  // Bus handshake state and acknowledge.
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      bus_state_q <= aawc_pkg::AAWC_ST_IDLE;
      ack_q       <= 1'b0;
    end
    else
    begin
      bus_state_q <= bus_state_d;
      ack_q       <= bus_req;
    end
  end

  // Read data mux; an unmapped offset reads as zero and still acknowledges.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_i)
      `AAWC_OFS_ACCESS_STATE_SELECT:
      begin
        rdata_d[7:0] = access_state_select_q;
      end
      `AAWC_OFS_WAIT_COUNT_UPPER:
      begin
        rdata_d[7:0] = wait_count_upper_areas_q;
      end
      `AAWC_OFS_WAIT_COUNT_LOWER:
      begin
        rdata_d[7:0] = wait_count_lower_areas_q;
      end
      `AAWC_OFS_LAST_TIMING:
      begin
        rdata_d[`AAWC_LT_STATES_LSB +: 3] = last_states_q;
        rdata_d[`AAWC_LT_WAITS_LSB +: 2]  = last_waits_q;
      end
      default:
      begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured when the request is taken and held with ack.
  // Capturing early keeps the read mux off the output, so wb_dat_o comes
  // straight from a flop.
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (bus_req && !wb_we_i)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Access state select; software standby has no input here, so the value
  // simply holds outside reset, hardware standby and writes.
  always_ff @(posedge clk_sys_i)
  begin
    if (hold_init)
    begin
      access_state_select_q <= `AAWC_RST_ACCESS_STATE_SELECT;
    end
    else if (wr_ass)
    begin
      access_state_select_q <= wb_dat_i[7:0];
    end
  end

  // Wait count registers for areas 7 to 4 and 3 to 0.
  always_ff @(posedge clk_sys_i)
  begin
    if (hold_init)
    begin
      wait_count_upper_areas_q <= `AAWC_RST_WAIT_COUNT_UPPER;
      wait_count_lower_areas_q <= `AAWC_RST_WAIT_COUNT_LOWER;
    end
    else
    begin
      // Without a write both registers keep their value outside reset and standby.
      if (wr_wcu)
      begin
        wait_count_upper_areas_q <= wb_dat_i[7:0];
      end
      else
      begin
        wait_count_upper_areas_q <= wait_count_upper_areas_q;
      end
      if (wr_wcl)
      begin
        wait_count_lower_areas_q <= wb_dat_i[7:0];
      end
      else
      begin
        wait_count_lower_areas_q <= wait_count_lower_areas_q;
      end
    end
  end

  // Upper register above lower puts area g at bits 2g+1 and 2g.
  assign wait_word = {wait_count_upper_areas_q, wait_count_lower_areas_q};

  // Per-area timing of an external access.
  // DRAM wins over the select bit, and only a three-state area reads its
  // wait field, so a two-state area never picks up a stale wait count.
  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_area
      always_comb
      begin
        area_waits[g]  = 2'h0;
        area_states[g] = `AAWC_STATES_TWO;
        if (dram_area_select_i[g])
        begin
          // DRAM timing is fixed by the DRAM interface, not by these bits.
          area_states[g] = `AAWC_STATES_DRAM;
        end
        else if (access_state_select_q[g])
        begin
          area_waits[g]  = wait_word[2*g +: 2];
          area_states[g] = `AAWC_STATES_THREE_BASE + {1'b0, area_waits[g]};
        end
        else
        begin
          area_waits[g]  = 2'h0;
          area_states[g] = `AAWC_STATES_TWO;
        end
      end
    end
  endgenerate

  // Answer for the current query; on-chip targets bypass every setting.
  // The area index is only looked at for external targets.
  always_comb
  begin
    answer_d = '0;
    if (query_i.valid)
    begin
      answer_d.valid = 1'b1;
      if (query_i.onchip)
      begin
        answer_d.states = `AAWC_STATES_ONCHIP;
        answer_d.waits  = 2'h0;
      end
      else
      begin
        answer_d.states = area_states[query_i.area];
        answer_d.waits  = area_waits[query_i.area];
      end
    end
  end

  // The answer is a one-cycle pulse a cycle after the query.
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      answer_q <= '0;
    end
    else
    begin
      answer_q <= answer_d;
    end
  end

  // Last answer seen, readable by software for debugging timing setups.
  // It holds while no query is made, so software can read it at leisure
  // after the cycle generator has gone quiet.
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      last_states_q <= 3'h0;
      last_waits_q  <= 2'h0;
    end
    else if (answer_d.valid)
    begin
      last_states_q <= answer_d.states;
      last_waits_q  <= answer_d.waits;
    end
  end

  // Registered copies of the settings for cycle generators that decode
  // themselves; one cycle of lag is harmless since software writes are rare.
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      three_state_q <= `AAWC_RST_ACCESS_STATE_SELECT;
      wait_counts_q <= {`AAWC_RST_WAIT_COUNT_UPPER, `AAWC_RST_WAIT_COUNT_LOWER};
    end
    else
    begin
      three_state_q <= access_state_select_q;
      wait_counts_q <= wait_word;
    end
  end

  assign wb_ack_o           = ack_q;
  assign wb_dat_o           = rdata_q;
  assign answer_o           = answer_q;
  assign area_three_state_o = three_state_q;
  assign area_wait_counts_o = wait_counts_q;

endmodule : aawc_top

// ==== sim/aawc_properties.sv ====
// Purpose: Assertions on the ports of aawc_top.
// Assumes: One clock domain and a synchronous active-low reset.
// Notes:   Each answer is tied to the query of the cycle before it.
`timescale 1ns/1ns
module aawc_properties (
  input wire logic                      clk_sys_i,
  input wire logic                      nrst_i,
  input wire logic                      hw_standby_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [7:0]                wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic [7:0]                dram_area_select_i,
  input wire aawc_pkg::aawc_query_type  query_i,
  input wire aawc_pkg::aawc_answer_type answer_o,
  input wire logic [7:0]                area_three_state_o,
  input wire logic [15:0]               area_wait_counts_o
);
  logic       ext_q;
  logic       onc_q;
  logic       drm_q;
  logic [2:0] area_q;

  // Kind of last query; reset clears it so no answer is expected just after release.
  always_ff @(posedge clk_sys_i)
  begin
    ext_q  <= nrst_i && query_i.valid && !query_i.onchip && !dram_area_select_i[query_i.area];
    onc_q  <= nrst_i && query_i.valid && query_i.onchip;
    drm_q  <= nrst_i && query_i.valid && !query_i.onchip && dram_area_select_i[query_i.area];
    area_q <= query_i.area;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_onchip;
    onc_q |-> answer_o.valid && answer_o.states == 3'h2 && answer_o.waits == 2'h0;
  endproperty
  property p_dram;
    drm_q |-> answer_o.valid && answer_o.states == 3'h3 && answer_o.waits == 2'h0;
  endproperty
  property p_two;
    ext_q && !area_three_state_o[area_q] |-> answer_o.valid && answer_o.states == 3'h2
      && answer_o.waits == 2'h0;
  endproperty
  property p_three;
    ext_q && area_three_state_o[area_q] |-> answer_o.valid
      && answer_o.waits == area_wait_counts_o[{area_q, 1'b0} +: 2]
      && answer_o.states == 3'h3 + {1'b0, answer_o.waits};
  endproperty
  property p_pulse;
    !query_i.valid |=> !answer_o.valid;
  endproperty
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  // The copies lag the registers by one cycle, so the second cycle after
  // release shows the registers themselves, not only the copies' reset.
  property p_rst;
    $rose(nrst_i) |-> (area_three_state_o == 8'hFF && area_wait_counts_o == 16'hFFFF)
      ##1 (area_three_state_o == 8'hFF && area_wait_counts_o == 16'hFFFF);
  endproperty
  // Standby passes two synchroniser flops, the register flop and the copy flop before it shows.
  property p_stby;
    hw_standby_i [*2] |-> ##3 (area_three_state_o == 8'hFF && area_wait_counts_o == 16'hFFFF);
  endproperty
  property p_hold;
    !hw_standby_i ##2 !(wb_cyc_i && wb_stb_i && wb_we_i) ##1 1'b1
      |=> $stable(area_three_state_o) && $stable(area_wait_counts_o);
  endproperty

  a_onchip: assert property (p_onchip)
    else $error("onchip timing wrong");
  a_dram: assert property (p_dram)
    else $error("dram timing wrong");
  a_two: assert property (p_two)
    else $error("two state timing wrong");
  a_three: assert property (p_three)
    else $error("three state timing wrong");
  a_pulse: assert property (p_pulse)
    else $error("answer without query");
  a_ack: assert property (p_ack)
    else $error("ack timing wrong");
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
  a_stby: assert property (p_stby)
    else $error("standby values wrong");
  a_hold: assert property (p_hold)
    else $error("config changed unasked");

  c_three: cover property (ext_q && area_three_state_o[area_q]);
  c_dram: cover property (drm_q);
  c_stby: cover property (hw_standby_i [*2]);
endmodule : aawc_properties

bind aawc_top aawc_properties i_aawc_properties (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hw_standby_i(hw_standby_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .dram_area_select_i(dram_area_select_i), .query_i(query_i), .answer_o(answer_o),
  .area_three_state_o(area_three_state_o), .area_wait_counts_o(area_wait_counts_o));

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the area timing configuration block.
// Assumes: Bus master and query driver both run on clk_sys_i.
// Notes:   Expected values queue up until the monitor sees a result.
`timescale 1ns/1ns
module testbench;
  logic                      clk_sys_i = 1'b0;
  logic                      nrst_i = 1'b0;
  logic                      hw_standby_i = 1'b0;
  logic                      wb_cyc_i = 1'b0;
  logic                      wb_stb_i = 1'b0;
  logic                      wb_we_i = 1'b0;
  logic [7:0]                wb_adr_i = 8'h00;
  logic [3:0]                wb_sel_i = 4'h0;
  logic [31:0]               wb_dat_i = 32'h0000_0000;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  logic [7:0]                dram_area_select_i = 8'h00;
  aawc_pkg::aawc_query_type  query_i = '0;
  aawc_pkg::aawc_answer_type answer_o;
  logic [7:0]                area_three_state_o;
  logic [15:0]               area_wait_counts_o;
  logic [31:0]               exp_rd[$];
  logic [31:0]               exp_ans[$];
  logic [15:0]               lfsr = 16'hA29C;
  logic [7:0]                ast_m;
  logic [7:0]                drm_m = 8'h00;
  logic [15:0]               wcr_m;
  logic [7:0]                last_m = 8'h00;
  int                        fails = 0;
  int                        checks_done = 0;

  aawc_top i_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hw_standby_i(hw_standby_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dram_area_select_i(dram_area_select_i), .query_i(query_i), .answer_o(answer_o),
    .area_three_state_o(area_three_state_o), .area_wait_counts_o(area_wait_counts_o));

  // System clock, 10 ns period.
  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict;
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // One classic cycle; the request holds until ack is sampled, so a slow slave is safe.
  task automatic wb_acc(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      fails++;
      print_verdict();
    end
  endtask : wb_acc

  task automatic wb_rd(input logic [7:0] adr, input logic [7:0] want);
    exp_rd.push_back({24'h00_0000, want});
    wb_acc(1'b0, adr, 4'hF, {lfsr, lfsr});
  endtask : wb_rd

  // Issues one query a cycle; on-chip wins over DRAM, DRAM over the select bit.
  // The last expected answer is also kept for the read-only timing word.
  task automatic qry(input logic [2:0] a, input logic onc);
    logic [1:0] w;
    logic [2:0] s;
    w = wcr_m[{a, 1'b0} +: 2];
    s = 3'h3 + {1'b0, w};
    if (onc || (!drm_m[a] && !ast_m[a]))
    begin
      s = 3'h2;
      w = 2'h0;
    end
    else if (drm_m[a])
    begin
      s = 3'h3;
      w = 2'h0;
    end
    exp_ans.push_back({27'h000_0000, s, w});
    last_m = {2'b00, w, 1'b0, s};
    query_i <= {1'b1, onc, a};
    @(posedge clk_sys_i);
  endtask : qry

  // Result monitor: the oldest note is compared with each answer seen.
  always @(posedge clk_sys_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check(wb_dat_o, exp_rd.pop_front());
    if (answer_o.valid === 1'b1)
      check({27'h000_0000, answer_o.states, answer_o.waits}, exp_ans.pop_front());
  end

  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    ast_m = 8'hFF;
    wcr_m = 16'hFFFF;
    wb_rd(8'h00, ast_m);
    wb_rd(8'h04, wcr_m[15:8]);
    wb_rd(8'h08, wcr_m[7:0]);
    qry(3'h5, 1'b0);
    query_i <= '0;
    // First round sets all four wait codes; later rounds are random.
    for (int r = 0; r < 8; r++)
    begin
      lfsr = lfsr_next(lfsr);
      ast_m = (r == 0) ? 8'hFF : lfsr[7:0];
      wcr_m = (r == 0) ? 16'h1BE4 : {lfsr[11:0], lfsr[15:12]};
      drm_m = (r < 2) ? 8'h00 : lfsr[15:8] & lfsr[9:2];
      dram_area_select_i <= drm_m;
      wb_acc(1'b1, 8'h00, 4'hF, {lfsr, 8'h00, ast_m});
      wb_acc(1'b1, 8'h04, 4'h1, {lfsr, 8'h00, wcr_m[15:8]});
      wb_acc(1'b1, 8'h08, 4'h1, {lfsr, 8'h00, wcr_m[7:0]});
      wb_rd(8'h00, ast_m);
      wb_rd(8'h04, wcr_m[15:8]);
      wb_rd(8'h08, wcr_m[7:0]);
      lfsr = lfsr_next(lfsr);
      for (int a = 0; a < 8; a++)
        qry(a[2:0], lfsr[a] & (r > 4));
      query_i <= '0;
      wb_rd(8'h0C, last_m);
    end
    // A write with lane 0 off is ignored; an unmapped place reads zero.
    wb_acc(1'b1, 8'h00, 4'hE, 32'h0000_0000);
    wb_rd(8'h00, ast_m);
    wb_rd(8'h10, 8'h00);
    hw_standby_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    hw_standby_i <= 1'b0;
    ast_m = 8'hFF;
    wcr_m = 16'hFFFF;
    wb_rd(8'h00, ast_m);
    wb_rd(8'h04, wcr_m[15:8]);
    wb_rd(8'h08, wcr_m[7:0]);
    // A mid-run reset after writes must bring back the all-ones values.
    wb_acc(1'b1, 8'h00, 4'h1, {lfsr, 16'h0000});
    wb_acc(1'b1, 8'h04, 4'h1, {lfsr, 16'h0000});
    wb_rd(8'h04, 8'h00);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    wb_rd(8'h00, 8'hFF);
    wb_rd(8'h04, 8'hFF);
    repeat (3) @(posedge clk_sys_i);
    check(32'(exp_rd.size() + exp_ans.size()), 32'h0000_0000);
    print_verdict();
  end
endmodule : testbench
